// File: design/bbsl_pkg.sv
// Shared constants, register map and state encodings of the supervisor
package bbsl_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int LDO_CL_QUAL_US  = 90;
   localparam int LDO_CL_QUAL_CYC = (LDO_CL_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LDO_RETRY_MS    = 100;
   localparam int LDO_RETRY_CYC   = LDO_RETRY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int LDO_SOFT_US     = 250;
   localparam int LDO_SOFT_CYC    = (LDO_SOFT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_SW_FREQ_HZ  = 31250;
   localparam int MIN_GAP_CYC     = 1000000000 / (MIN_SW_FREQ_HZ * CLK_PERIOD_NS);
   localparam int TMR_W           = 24;
   // Voltages in millivolts
   localparam int MV_W            = 15;
   localparam int LDO_BASE_MV     = 2000;
   localparam int LDO_STEP_MV     = 100;
   localparam int UVLO_PCT        = 88;
   localparam int VIN_LDO_MIN_MV  = 3900;
   localparam int MARGIN_STEP_MV  = 100;
   // Register indices, byte address is four times the index
   localparam logic [5:0] REG_LDO_CFG = 6'h01;
   localparam logic [5:0] REG_FAULT   = 6'h05;
   localparam logic [5:0] REG_STATE   = 6'h06;
   localparam logic [5:0] REG_SRC     = 6'h0b;
   localparam logic [5:0] REG_MODE    = 6'h10;
   localparam logic [5:0] REG_LDO_V   = 6'h11;
   localparam logic [5:0] REG_XOVER   = 6'h12;
   localparam logic [5:0] REG_MASK    = 6'h1e;
   // Field positions
   localparam int LDO_DIS_BIT      = 0;
   localparam int LDO_FAULT_BIT    = 1 - 1;
   localparam int IRQ_RELEASE_BIT  = 1;
   localparam int SRC_MANUAL_BIT   = 0;
   localparam int SRC_CHOICE_BIT   = 1;
   localparam int FORCE_PWM_BIT    = 0;
   localparam int IGNORE_FLT_BIT   = 1;
   localparam int MIN_FREQ_BIT     = 2;
   localparam int BOOST_MARGIN_LSB = 8;
   // Reset values
   localparam logic [4:0] BUCK_MARGIN_RST  = 5'h0a;
   localparam logic [4:0] BOOST_MARGIN_RST = 5'h14;
   localparam logic [3:0] MASK_RST         = 4'h0;
   // State encodings
   typedef enum logic [2:0] {P_STBY = 3'h1, P_ON = 3'h2, P_FAULT = 3'h4} bbsl_pwr_t;
   typedef enum logic [2:0] {T_BUCK = 3'h1, T_BB = 3'h2, T_BOOST = 3'h4} bbsl_topo_t;
   typedef enum logic [3:0] {L_OFF = 4'h1, L_SOFT = 4'h2, L_ON = 4'h4, L_WAIT = 4'h8} bbsl_ldo_t;
endpackage

// File: design/bbsl_tmr_if.sv
// Control and status bundle between the supervisor and one of its timers
`timescale 1ns/1ps
`default_nettype none
interface bbsl_tmr_if #(parameter int W = 24);
   logic         clear;
   logic         run;
   logic [W-1:0] limit;
   logic         done;
   modport owner (output clear, output run, output limit, input done);
   modport timer (input clear, input run, input limit, output done);
endinterface
`default_nettype wire

// File: design/bbsl_sync.sv
// Two-stage synchroniser for pin inputs and measurement words
`timescale 1ns/1ps
`default_nettype none
module bbsl_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// Saturating cycle counter, done while the count equals the limit
module bbsl_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  rst_b,
   // Control
   bbsl_tmr_if.timer  t
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (t.clear) begin
         cnt_q <= '0;
      end else if (t.run && cnt_q != t.limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign t.done = (cnt_q == t.limit);
endmodule
`default_nettype wire

// File: design/bbsl_top.sv
// Buck-boost supervisor with auxiliary LDO control behind a Wishbone slave
// Functional notes
// RULE1: Status pin pulled low only when enabled and valid, else released.
// RULE2: Any unmasked status change pulls the interrupt pin low.
// RULE3: Interrupt released only after a status read and with fault gone.
// RULE4: Buck to buck-boost below buck margin; to boost above boost margin.
// RULE5: Per topology, switches held on, off or switching as tabulated.
// RULE6: Force-PWM bit 0 allows pulse skipping; 1 keeps fixed PWM.
// RULE7: Minimum-frequency bit keeps skipping rate at or above 31.25kHz.
// RULE8: Power-up in standby with defaults; active while enable pin high.
// RULE9: LDO on in standby if input above 3.9V and disable bit clear.
// RULE10: LDO target is 2.0V plus 100mV times the 5-bit code.
// RULE11: Auto source picks lower rail, higher rail if headroom is short.
// RULE12: Manual bit selects choice bit: 0 output rail, 1 input rail.
// RULE13: LDO fault stops the converter and sets the LDO fault flag.
// RULE14: Current limit beyond 90us turns LDO off 100ms, then retries.
// RULE15: LDO undervoltage flagged below 88% of programmed target.
// RULE16: LDO current-limit timeout or undervoltage moves power to fault-hold.
// RULE17: Ignore-fault bit keeps converter running through LDO faults.
// RULE18: Every LDO enable ramps with a fixed 250us soft-start.
// RULE19: Standby disables the converter while the LDO may stay on.
// RULE20: Writing 1 to release bit frees interrupt; bit always reads 0.
// RULE21: Current-limit count restarts from zero with each retry soft-start.
`timescale 1ns/1ps
`default_nettype none
module bbsl_top import bbsl_pkg::*; #(
   parameter int         LDO_RETRY_CYCLES = LDO_RETRY_CYC,
   parameter logic       LDO_DIS_FACTORY  = 1'b0,
   parameter logic [4:0] LDO_CODE_DEFAULT = 5'h0d,
   parameter int         DROPOUT_MV       = 300
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rst_b,
   // Wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // Converter status pins
   input  wire logic            enPin,
   input  wire logic            outputValid,
   input  wire logic            hiccupActive,
   input  wire logic            lightLoadDis,
   input  wire logic            lightLoad,
   input  wire logic            pwmDrive,
   input  wire logic            ldoCurrentLimit,
   input  wire logic [MV_W-1:0] vinMv,
   input  wire logic [MV_W-1:0] voutMv,
   input  wire logic [MV_W-1:0] ldoOutMv,
   // Power stage and LDO control
   output logic      [3:0]      switchGate,
   output logic                 converterRun,
   output logic                 ldoEnable,
   output logic                 ldoSoftStart,
   output logic                 ldoFromVin,
   // Open-drain status and interrupt pins
   input  wire logic            statIn,
   output logic                 statOut,
   output logic                 statOe,
   input  wire logic            faultInterruptIn_n,
   output logic                 faultInterruptOut_n,
   output logic                 faultInterruptOe
);
   // Pin synchronisers
   logic [8:0]        pinS;
   logic [3*MV_W-1:0] mvS;
   logic              enS, validS, hiccupS, lldS, lightS, pwmS, clS, statInS, irqInS;
   logic [MV_W-1:0]   vinS, voutS, ldoOutS;

   bbsl_sync #(.W(9)) u_syncPins (
      .clock (clock),
      .rst_b (rst_b),
      .d     ({enPin, outputValid, hiccupActive, lightLoadDis, lightLoad, pwmDrive,
               ldoCurrentLimit, statIn, faultInterruptIn_n}),
      .q     (pinS)
   );
   // Slow measurement words, assumed to settle well within a sample
   bbsl_sync #(.W(3 * MV_W)) u_syncMv (
      .clock (clock),
      .rst_b (rst_b),
      .d     ({vinMv, voutMv, ldoOutMv}),
      .q     (mvS)
   );
   assign {enS, validS, hiccupS, lldS, lightS, pwmS, clS, statInS, irqInS} = pinS;
   assign {vinS, voutS, ldoOutS} = mvS;

   // Register bus decode
   logic        ack_q;
   logic [31:0] rdData;
   logic [31:0] dat_q;
   logic [5:0]  idx;
   logic        wbHit, wrEn, rdEn;
   assign idx   = wb_adr_i[7:2];
   assign wbHit = wb_cyc_i && wb_stb_i && !ack_q;
   assign wrEn  = wbHit && wb_we_i;
   assign rdEn  = wbHit && !wb_we_i;

   // Software configuration
   logic       ldoDis_q, srcManual_q, srcChoice_q, forcePwm_q, ignFlt_q, minFreq_q;
   logic [4:0] ldoCode_q, buckM_q, boostM_q;
   logic [3:0] mask_q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ldoDis_q    <= LDO_DIS_FACTORY;
         srcManual_q <= 1'b0;
         srcChoice_q <= 1'b0;
         forcePwm_q  <= 1'b0;
         ignFlt_q    <= 1'b0;
         minFreq_q   <= 1'b0;
         ldoCode_q   <= LDO_CODE_DEFAULT;
         buckM_q     <= BUCK_MARGIN_RST;
         boostM_q    <= BOOST_MARGIN_RST;
         mask_q      <= MASK_RST;
      end else if (wrEn) begin
         if (wb_sel_i[0]) begin
            case (idx)
               REG_LDO_CFG: ldoDis_q <= wb_dat_i[LDO_DIS_BIT];
               REG_SRC: begin
                  srcManual_q <= wb_dat_i[SRC_MANUAL_BIT];
                  srcChoice_q <= wb_dat_i[SRC_CHOICE_BIT];
               end
               REG_MODE: begin
                  forcePwm_q <= wb_dat_i[FORCE_PWM_BIT];
                  ignFlt_q   <= wb_dat_i[IGNORE_FLT_BIT];
                  minFreq_q  <= wb_dat_i[MIN_FREQ_BIT];
               end
               REG_LDO_V:  ldoCode_q <= wb_dat_i[4:0];
               REG_XOVER:  buckM_q   <= wb_dat_i[4:0];
               REG_MASK:   mask_q    <= wb_dat_i[3:0];
               default: ;
            endcase
         end
         if (wb_sel_i[1] && idx == REG_XOVER) begin
            boostM_q <= wb_dat_i[BOOST_MARGIN_LSB +: 5];
         end
      end
   end

   // State registers
   bbsl_pwr_t  pwrSt_q, pwrSt_d;
   bbsl_ldo_t  ldoSt_q, ldoSt_d;
   bbsl_topo_t topo_q, topo_d;

   // LDO target, undervoltage and supply choice
   logic [12:0]     targetMv;
   logic [23:0]     uvloLhs, uvloRhs;
   logic            uvlo, vinOk, ldoAllowed, ldoFaultNow, ldoBlock;
   logic [MV_W-1:0] lowerMv;
   logic            lowerIsVin, headroomOk, srcVin;
   assign targetMv    = 13'(LDO_BASE_MV + LDO_STEP_MV * int'(ldoCode_q)); // RULE10
   assign uvloLhs     = 24'(ldoOutS) * 24'd100;
   assign uvloRhs     = 24'(targetMv) * 24'(UVLO_PCT);
   assign uvlo        = uvloLhs < uvloRhs; // RULE15
   assign vinOk       = vinS > MV_W'(VIN_LDO_MIN_MV);
   assign ldoAllowed  = vinOk && !ldoDis_q; // RULE9
   assign ldoFaultNow = (ldoSt_q == L_WAIT) || (ldoSt_q == L_ON && uvlo); // RULE13
   assign ldoBlock    = ldoFaultNow && !ignFlt_q; // RULE17
   assign lowerIsVin  = vinS <= voutS;
   assign lowerMv     = lowerIsVin ? vinS : voutS;
   assign headroomOk  = lowerMv >= MV_W'(int'(targetMv) + DROPOUT_MV); // RULE11
   assign srcVin      = srcManual_q ? srcChoice_q : (lowerIsVin == headroomOk); // RULE12

   // LDO timers
   bbsl_tmr_if #(.W(TMR_W)) qualIf ();
   bbsl_tmr_if #(.W(TMR_W)) softIf ();
   bbsl_tmr_if #(.W(TMR_W)) waitIf ();
   assign qualIf.limit = TMR_W'(LDO_CL_QUAL_CYC);
   assign qualIf.run   = clS && (ldoSt_q == L_SOFT || ldoSt_q == L_ON);
   assign qualIf.clear = !clS || ldoSt_q == L_WAIT || ldoSt_q == L_OFF; // RULE21
   assign softIf.limit = TMR_W'(LDO_SOFT_CYC);
   assign softIf.run   = ldoSt_q == L_SOFT;
   assign softIf.clear = ldoSt_q != L_SOFT; // RULE18
   assign waitIf.limit = TMR_W'(LDO_RETRY_CYCLES);
   assign waitIf.run   = ldoSt_q == L_WAIT;
   assign waitIf.clear = ldoSt_q != L_WAIT;

   bbsl_timer #(.W(TMR_W)) u_qualTmr (.clock(clock), .rst_b(rst_b), .t(qualIf));
   bbsl_timer #(.W(TMR_W)) u_softTmr (.clock(clock), .rst_b(rst_b), .t(softIf));
   bbsl_timer #(.W(TMR_W)) u_waitTmr (.clock(clock), .rst_b(rst_b), .t(waitIf));

   // LDO sequencing
   always_comb begin
      ldoSt_d = ldoSt_q;
      unique case (ldoSt_q)
         L_OFF:  if (ldoAllowed) ldoSt_d = L_SOFT;
         L_SOFT: begin
            if (!ldoAllowed) ldoSt_d = L_OFF;
            else if (qualIf.done) ldoSt_d = L_WAIT; // RULE14
            else if (softIf.done) ldoSt_d = L_ON;
         end
         L_ON: begin
            if (!ldoAllowed) ldoSt_d = L_OFF;
            else if (qualIf.done) ldoSt_d = L_WAIT; // RULE14
         end
         L_WAIT: if (waitIf.done) ldoSt_d = ldoAllowed ? L_SOFT : L_OFF; // RULE14
         default: ldoSt_d = L_OFF;
      endcase
   end

   // Power state
   always_comb begin
      pwrSt_d = pwrSt_q;
      unique case (pwrSt_q)
         P_STBY:  if (enS && !ldoBlock) pwrSt_d = P_ON; // RULE8
         P_ON: begin
            if (!enS) pwrSt_d = P_STBY;
            else if (ldoBlock) pwrSt_d = P_FAULT; // RULE16
         end
         P_FAULT: begin
            if (!enS) pwrSt_d = P_STBY;
            else if (!ldoBlock) pwrSt_d = P_ON;
         end
         default: pwrSt_d = P_STBY;
      endcase
   end

   // Topology steps between neighbours, one shared threshold per pair
   logic signed [MV_W:0] inMinusOut;
   logic        [MV_W-1:0] buckMv, boostMv;
   assign inMinusOut = $signed({1'b0, vinS}) - $signed({1'b0, voutS});
   assign buckMv     = MV_W'(int'(buckM_q) * MARGIN_STEP_MV);
   assign boostMv    = MV_W'(int'(boostM_q) * MARGIN_STEP_MV);
   always_comb begin
      topo_d = topo_q;
      unique case (topo_q)
         T_BUCK:  if (inMinusOut < $signed({1'b0, buckMv})) topo_d = T_BB; // RULE4
         T_BB: begin
            if (-inMinusOut > $signed({1'b0, boostMv})) topo_d = T_BOOST; // RULE4
            else if (inMinusOut >= $signed({1'b0, buckMv})) topo_d = T_BUCK;
         end
         T_BOOST: if (-inMinusOut <= $signed({1'b0, boostMv})) topo_d = T_BB;
         default: topo_d = T_BUCK;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pwrSt_q <= P_STBY;
         ldoSt_q <= L_OFF;
         topo_q  <= T_BUCK;
      end else begin
         pwrSt_q <= pwrSt_d;
         ldoSt_q <= ldoSt_d;
         topo_q  <= topo_d;
      end
   end

   // Pulse skipping with an optional floor on switching rate
   logic       skip_q, skipD;
   logic [9:0] gapCnt_q;
   assign skipD = lightS && !forcePwm_q // RULE6
                  && !(minFreq_q && gapCnt_q >= 10'(MIN_GAP_CYC - 1)); // RULE7
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         skip_q   <= 1'b0;
         gapCnt_q <= '0;
      end else begin
         skip_q <= skipD;
         if (!skip_q) gapCnt_q <= '0;
         else if (gapCnt_q != '1) gapCnt_q <= gapCnt_q + 1'b1;
      end
   end

   // Power stage, LDO and status pin outputs
   logic swOn;
   assign swOn = pwrSt_q == P_ON && !skip_q; // RULE19
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         switchGate   <= 4'h0;
         converterRun <= 1'b0;
         ldoEnable    <= 1'b0;
         ldoSoftStart <= 1'b0;
         ldoFromVin   <= 1'b0;
         statOe       <= 1'b0;
         statOut      <= 1'b0;
      end else begin
         if (!swOn) switchGate <= 4'h0;
         else begin
            unique case (topo_q)
               T_BUCK:  switchGate <= {pwmS, !pwmS, 1'b0, 1'b1}; // RULE5
               T_BB:    switchGate <= {pwmS, !pwmS, !pwmS, pwmS}; // RULE5
               T_BOOST: switchGate <= {1'b1, 1'b0, !pwmS, pwmS}; // RULE5
               default: switchGate <= 4'h0;
            endcase
         end
         converterRun <= pwrSt_d == P_ON; // RULE13
         ldoEnable    <= ldoSt_d == L_SOFT || ldoSt_d == L_ON;
         ldoSoftStart <= ldoSt_d == L_SOFT;
         ldoFromVin   <= srcVin;
         statOe       <= pwrSt_q == P_ON && validS && !hiccupS && !lldS; // RULE1
      end
   end

   // Fault flag and interrupt; a new event always beats a clear
   logic       ldoFlag_q, readSeen_q, irq_q;
   logic [3:0] stPrev_q, stNow, evt;
   logic       faultRd, irqRelease;
   assign stNow      = {topo_q != T_BUCK, pwrSt_q == P_ON, statOe, ldoFaultNow};
   assign evt        = (stNow ^ stPrev_q) & ~mask_q; // RULE2
   assign faultRd    = rdEn && idx == REG_FAULT;
   assign irqRelease = wrEn && wb_sel_i[0] && idx == REG_FAULT && wb_dat_i[IRQ_RELEASE_BIT] // RULE20
                       && readSeen_q && !(ldoFaultNow && !mask_q[0]); // RULE3
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ldoFlag_q  <= 1'b0;
         readSeen_q <= 1'b0;
         irq_q      <= 1'b0;
         stPrev_q   <= '0;
      end else begin
         stPrev_q   <= stNow;
         ldoFlag_q  <= ldoFaultNow || (ldoFlag_q && !faultRd); // RULE13
         irq_q      <= (|evt) || (irq_q && !irqRelease);
         readSeen_q <= (faultRd && irq_q) || (readSeen_q && !irqRelease && irq_q);
      end
   end
   assign faultInterruptOe    = irq_q;
   assign faultInterruptOut_n = 1'b0;

   // Register read path
   always_comb begin
      rdData = '0;
      case (idx)
         REG_LDO_CFG: rdData[LDO_DIS_BIT] = ldoDis_q;
         REG_FAULT:   rdData[LDO_FAULT_BIT] = ldoFlag_q; // RULE20
         REG_STATE:   rdData[11:0] = {irqInS, statInS, ldoSt_q, topo_q, pwrSt_q};
         REG_SRC: begin
            rdData[SRC_MANUAL_BIT] = srcManual_q;
            rdData[SRC_CHOICE_BIT] = srcChoice_q;
         end
         REG_MODE: begin
            rdData[FORCE_PWM_BIT]  = forcePwm_q;
            rdData[IGNORE_FLT_BIT] = ignFlt_q;
            rdData[MIN_FREQ_BIT]   = minFreq_q;
         end
         REG_LDO_V:   rdData[4:0] = ldoCode_q;
         REG_XOVER:   rdData[12:0] = {boostM_q, 3'h0, buckM_q};
         REG_MASK:    rdData[3:0] = mask_q;
         default: ;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= wbHit;
         if (rdEn) dat_q <= rdData;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence sQualHit;
      ldoSt_q == L_ON && qualIf.done && ldoAllowed;
   endsequence
   sequence sOffPeriod;
      ldoSt_q == L_WAIT && !ldoEnable;
   endsequence

   statRelease_a: assert property (!validS |=> !statOe) else $error("status pin driven while invalid"); // RULE1
   irqRaise_a: assert property (|evt |=> faultInterruptOe) else $error("interrupt missed an event"); // RULE2
   irqHold_a: assert property (irq_q && ldoFaultNow && !mask_q[0] |=> faultInterruptOe)
      else $error("interrupt dropped with fault present"); // RULE3
   topoCross_a: assert property (topo_q == T_BUCK && inMinusOut < $signed({1'b0, buckMv}) |=> topo_q == T_BB)
      else $error("buck crossover missed"); // RULE4
   gateBuck_a: assert property (topo_q == T_BUCK && swOn |=> switchGate[1:0] == 2'h1)
      else $error("buck switch pattern wrong"); // RULE5
   pwmForce_a: assert property (forcePwm_q |=> !skip_q) else $error("skipping with forced pwm"); // RULE6
   minFreq_a: assert property (minFreq_q && gapCnt_q >= 10'(MIN_GAP_CYC - 1) |=> !skip_q)
      else $error("skip gap exceeded"); // RULE7
   ldoRetry_a: assert property (sQualHit |=> sOffPeriod) else $error("ldo not off after limit"); // RULE14
   retryCount_a: assert property (ldoSt_q == L_SOFT && $past(ldoSt_q) == L_WAIT |-> !qualIf.done)
      else $error("qualification count not restarted"); // RULE21
   faultHold_a: assert property (pwrSt_q == P_ON && enS && ldoBlock |=> pwrSt_q == P_FAULT && !converterRun)
      else $error("ldo fault did not stop converter"); // RULE16
   releaseZero_a: assert property (ack_q && $past(faultRd) |-> !wb_dat_o[IRQ_RELEASE_BIT])
      else $error("release bit read as one"); // RULE20
endmodule
`default_nettype wire

// File: sim/bbsl_host_model.sv
// Host model: Wishbone master that services the interrupt line
`timescale 1ns/1ps
`default_nettype none
module bbsl_host_model import bbsl_pkg::*; (
   // Clock
   input  wire logic        clock,
   // Wishbone master
   output var  logic        wb_cyc_o,
   output var  logic        wb_stb_o,
   output var  logic        wb_we_o,
   output var  logic [7:0]  wb_adr_o,
   output var  logic [3:0]  wb_sel_o,
   output var  logic [31:0] wb_dat_o,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end
   // Request held until ack is sampled; no fixed latency assumed
   task automatic access(input logic we, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= {idx, 2'h0};
      wb_sel_o <= 4'h3;
      wb_dat_o <= wd;
      @(posedge clock);
      while (wb_ack_i !== 1'b1) @(posedge clock);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
   endtask
   // Status read must come first, else the release is premature
   task automatic release_irq(output logic [31:0] st);
      logic [31:0] d;
      access(1'b0, REG_FAULT, 32'h0, st);
      access(1'b1, REG_FAULT, 32'h2, d);
   endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the buck-boost supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top import bbsl_pkg::*;;
   typedef struct {logic [14:0] vin; logic [14:0] vout; logic [2:0] topo; logic [3:0] gm; logic [3:0] gv; logic src;} bbsl_row_t;
   bbsl_row_t   rows[3] = '{'{15'h2ee0, 15'h1388, 3'h1, 4'h3, 4'h1, 1'b0},
                           '{15'h2328, 15'h2134, 3'h2, 4'hf, 4'h6, 1'b0},
                           '{15'h1388, 15'h2328, 3'h4, 4'hc, 4'h8, 1'b1}};
   logic        clock, rst_b, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel, switchGate;
   logic [31:0] wdat, rdat, rv;
   logic        enPin, outputValid, hiccupActive, ldoCurrentLimit, converterRun, ldoEnable, ldoSoftStart;
   logic        ldoFromVin, statOut, statOe, irqOut_n, faultInterruptOe, lightLoad, pwmDrive;
   logic [14:0] vinMv, voutMv, ldoOutMv;
   int          fail_count, cmp_count;
   wire         statPin = statOe ? statOut : 1'b1;
   wire         irqPin  = faultInterruptOe ? irqOut_n : 1'b1;
   bbsl_top #(.LDO_RETRY_CYCLES(50)) bbsl_top_inst (.clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .enPin(enPin),
      .outputValid(outputValid), .hiccupActive(hiccupActive), .lightLoadDis(lightLoad), .lightLoad(lightLoad),
      .pwmDrive(pwmDrive),
      .ldoCurrentLimit(ldoCurrentLimit), .vinMv(vinMv), .voutMv(voutMv), .ldoOutMv(ldoOutMv), .switchGate(switchGate),
      .converterRun(converterRun), .ldoEnable(ldoEnable), .ldoSoftStart(ldoSoftStart), .ldoFromVin(ldoFromVin),
      .statIn(statPin), .statOut(statOut), .statOe(statOe), .faultInterruptIn_n(irqPin),
      .faultInterruptOut_n(irqOut_n), .faultInterruptOe(faultInterruptOe));
   bbsl_host_model bbsl_host_model_inst (.clock(clock), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
      .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
   always #50 clock = ~clock;
   task chkB(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task chkW(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [5:0] i, input logic [31:0] d);
      bbsl_host_model_inst.access(1'b1, i, d, rv);
   endtask
   task rd(input logic [5:0] i);
      bbsl_host_model_inst.access(1'b0, i, 32'h0, rv);
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      results();
   end
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      {enPin, outputValid, hiccupActive, ldoCurrentLimit, lightLoad, pwmDrive} = 6'h0;
      vinMv = 15'h2ee0;
      voutMv = 15'h1388;
      ldoOutMv = 15'h0ce4;
      repeat (10) @(posedge clock);
      chkB(ack, 1'b0);
      chkB(ldoEnable, 1'b0);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      chkB(ldoSoftStart, 1'b1);
      chkB(converterRun, 1'b0);
      foreach (rows[i]) begin
         rd(i == 0 ? REG_LDO_V : i == 1 ? REG_XOVER : 6'h3f);
         chkW(rv, i == 0 ? 32'h0d : i == 1 ? 32'h140a : 32'h0);
      end
      rd(REG_STATE);
      chkW(rv & 32'h3c7, 32'h081);
      repeat (2300) @(posedge clock);
      chkB(ldoSoftStart, 1'b1);
      repeat (300) @(posedge clock);
      chkB(ldoSoftStart, 1'b0);
      chkB(ldoEnable, 1'b1);
      enPin <= 1'b1;
      outputValid <= 1'b1;
      repeat (8) @(posedge clock);
      chkB(converterRun, 1'b1);
      chkB(statOe, 1'b1);
      chkB(statPin, 1'b0);
      chkB(faultInterruptOe, 1'b1);
      chkB(irqPin, 1'b0);
      foreach (rows[i]) begin
         vinMv <= rows[i].vin;
         voutMv <= rows[i].vout;
         repeat (8) @(posedge clock);
         rd(REG_STATE);
         chkW(rv & 32'h38, {26'h0, rows[i].topo, 3'h0});
         chkW({28'h0, switchGate & rows[i].gm}, {28'h0, rows[i].gv});
         chkB(ldoFromVin, rows[i].src);
      end
      pwmDrive <= 1'b1;
      lightLoad <= 1'b1;
      repeat (6) @(posedge clock);
      chkW({28'h0, switchGate}, 32'h0);
      chkB(statOe, 1'b0);
      wr(REG_MODE, 32'h1);
      repeat (4) @(posedge clock);
      chkW({28'h0, switchGate}, 32'h9);
      // Floor on skip rate, watched by its assertion
      wr(REG_MODE, 32'h4);
      repeat (700) @(posedge clock);
      lightLoad <= 1'b0;
      repeat (6) @(posedge clock);
      bbsl_host_model_inst.release_irq(rv);
      repeat (4) @(posedge clock);
      chkB(faultInterruptOe, 1'b0);
      rd(REG_FAULT);
      chkW(rv & 32'h3, 32'h0);
      wr(REG_SRC, 32'h1);
      repeat (2) @(posedge clock);
      chkB(ldoFromVin, 1'b0);
      wr(REG_SRC, 32'h3);
      repeat (2) @(posedge clock);
      chkB(ldoFromVin, 1'b1);
      hiccupActive <= 1'b1;
      repeat (6) @(posedge clock);
      chkB(statOe, 1'b0);
      hiccupActive <= 1'b0;
      wr(REG_LDO_V, 32'h1f);
      repeat (6) @(posedge clock);
      chkB(converterRun, 1'b0);
      chkB(faultInterruptOe, 1'b1);
      rd(REG_FAULT);
      chkW(rv & 32'h1, 32'h1);
      wr(REG_LDO_V, 32'h0d);
      repeat (6) @(posedge clock);
      chkB(converterRun, 1'b1);
      bbsl_host_model_inst.release_irq(rv);
      repeat (4) @(posedge clock);
      chkB(faultInterruptOe, 1'b0);
      wr(REG_MODE, 32'h2);
      ldoCurrentLimit <= 1'b1;
      repeat (880) @(posedge clock);
      chkB(ldoEnable, 1'b1);
      repeat (40) @(posedge clock);
      chkB(ldoEnable, 1'b0);
      chkB(converterRun, 1'b1);
      repeat (60) @(posedge clock);
      chkB(ldoSoftStart, 1'b1);
      ldoCurrentLimit <= 1'b0;
      wr(REG_MASK, 32'hf);
      bbsl_host_model_inst.release_irq(rv);
      enPin <= 1'b0;
      repeat (8) @(posedge clock);
      chkB(converterRun, 1'b0);
      chkB(ldoEnable, 1'b1);
      chkB(faultInterruptOe, 1'b0);
      results();
   end
endmodule
`default_nettype wire
